/* File: logic/dla_sampler.sv */
// data-address sampling counters and off-core response filter
// Summary of operation
// - sampling only on the four lowest counters
// - enabled counter overflow starts a sample record
// - overflow latches address and status for record
// - only listed events capture; all-retired needs tag
// - sample enable bit also enables address capture
// - fill address, store status, zero reserved entry
// - address entry holds load or store address
// - store status bit zero is L1 hit
// - hit flag defined only for store events
// - record holds triggering instruction pointer
// - early pointer field holds next instruction
// - filter holds request, supplier, snoop fields
// - bits 0-2 demand data, ownership, code
// - bit 3 modified line write-backs
// - bits 4-6 level-two prefetch kinds
// - bits 7-9 level-three prefetch kinds
// - bit 10 split or uncached locks
// - bit 11 streaming stores
// - lowest supplier bit matches any response
//
// Register access over Wishbone and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
module dla_sampler
  import dla_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [WB_AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // retirement pipeline
  input wire logic ret_valid_i,
  input wire logic [EV_SPACE-1:0] ret_event_i,
  input wire logic ret_is_load_i,
  input wire logic ret_is_store_i,
  input wire logic ret_tagged_i,
  input wire logic ret_l1_hit_i,
  input wire logic [63:0] ret_lin_addr_i,
  input wire logic [63:0] ret_ip_i,
  input wire logic [63:0] ret_next_ip_i,
  // off-core requests
  input wire logic oc_valid_i,
  input wire logic [REQ_W-1:0] oc_req_i,
  input wire logic [SUPP_W-1:0] oc_supp_i,
  input wire logic [SNP_W-1:0] oc_snoop_i,
  // sample buffer
  input wire logic rec_ready_i,
  output logic rec_valid_o,
  output logic [7:0] rec_offset_o,
  output logic [63:0] rec_data_o,
  output logic rec_last_o
);
  // ****************************************
  // state
  // ****************************************
  logic [NUM_CNT-1:0] smp_en_ff;
  logic [7:0] evsel_ff [NUM_CNT];
  logic [CNT_W-1:0] cnt_ff [NUM_CNT];
  logic [NUM_CNT-1:0] ovf;
  logic [FILT_W-1:0] filt_ff;
  logic [CNT_W-1:0] oc_cnt_ff;
  logic [DROP_W-1:0] drop_ff;
  logic [SMP_W-1:0] smp_cnt_ff;
  logic ack_ff;
  logic [31:0] rd_ff;
  logic wr_req;
  logic busy;
  logic fire;
  logic [EV_W-1:0] fire_code;
  logic qual;
  logic st_meaning;
  logic [63:0] nxt_lin_addr;
  logic [63:0] nxt_store_stat;
  logic oc_match;
  logic start;
  logic [31:0] status_word;
  logic sel_en;
  logic sel_flo;
  logic sel_fhi;
  logic sel_stat;
  logic sel_occ;
  logic [NUM_CNT-1:0] sel_evsel;
  logic [NUM_CNT-1:0] sel_cnt;

  // ****************************************
  // wishbone slave
  // ****************************************
  // true when the word address matches a register
  function automatic logic hit(input logic [WB_AW-1:0] a, input logic [7:0] off);
    return (a[WB_AW-1:2] == off[WB_AW-1:2]);
  endfunction : hit

  // merge write data by byte lanes
  function automatic logic [31:0] lanes(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction : lanes

  // ****************************************
  // register decode
  // ****************************************
  // selects decoded once; the read mux and every write path share them
  always_comb begin
    sel_en = hit(wb_adr_i, OFF_SAMPLE_EN);
    sel_flo = hit(wb_adr_i, OFF_FILT_LO);
    sel_fhi = hit(wb_adr_i, OFF_FILT_HI);
    sel_stat = hit(wb_adr_i, OFF_STATUS);
    sel_occ = hit(wb_adr_i, OFF_OC_CNT);
    for (int i = 0; i < NUM_CNT; i++) begin
      sel_evsel[i] = hit(wb_adr_i, OFF_EVSEL0 + 8'(i) * OFF_STRIDE);
      sel_cnt[i] = hit(wb_adr_i, OFF_CNT0 + 8'(i) * OFF_STRIDE);
    end
  end

  // status: records started, records dropped, writer busy
  assign status_word = {smp_cnt_ff, drop_ff, 7'h0, busy};

  // a write takes effect once, in the cycle that raises ack
  assign wr_req = wb_cyc_i && wb_stb_i && wb_we_i && !ack_ff;
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rd_ff;

  // one wait state; ack drops the cycle after it was given
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= wb_cyc_i && wb_stb_i && !ack_ff;
    end
  end

  // read mux; unmapped addresses answer with zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_ff <= 32'h0;
    end else if (wb_cyc_i && wb_stb_i && !ack_ff) begin
      rd_ff <= 32'h0;
      if (sel_en) begin
        rd_ff <= {28'h0, smp_en_ff};
      end
      for (int i = 0; i < NUM_CNT; i++) begin
        if (sel_evsel[i]) begin
          rd_ff <= {24'h0, evsel_ff[i]};
        end
        if (sel_cnt[i]) begin
          rd_ff <= cnt_ff[i];
        end
      end
      if (sel_flo) begin
        rd_ff <= filt_ff[31:0];
      end
      if (sel_fhi) begin
        rd_ff <= {26'h0, filt_ff[FILT_W-1:32]};
      end
      if (sel_stat) begin
        rd_ff <= status_word;
      end
      if (sel_occ) begin
        rd_ff <= oc_cnt_ff;
      end
    end
  end

  // ****************************************
  // sampling configuration
  // ****************************************
  // only four enable bits exist, so no higher counter can sample
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      smp_en_ff <= 4'h0;
    end else if (wr_req && sel_en && wb_sel_i[0]) begin
      smp_en_ff <= wb_dat_i[NUM_CNT-1:0];
    end
  end

  // ****************************************
  // general counters
  // ****************************************
  // a software write to a counter wins over a counted event that cycle
  generate
    for (genvar g = 0; g < NUM_CNT; g++) begin : g_cnt
      logic inc;
      assign inc = ret_valid_i && evsel_ff[g][EVSEL_EN_BIT] &&
                   ret_event_i[evsel_ff[g][EV_W-1:0]];
      assign ovf[g] = inc && (cnt_ff[g] == {CNT_W{1'b1}});

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          evsel_ff[g] <= 8'h0;
        end else if (wr_req && sel_evsel[g] && wb_sel_i[0]) begin
          // only the low byte exists, so only lane zero can change it
          evsel_ff[g] <= wb_dat_i[7:0];
        end
      end

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          cnt_ff[g] <= '0;
        end else if (wr_req && sel_cnt[g]) begin
          cnt_ff[g] <= lanes(cnt_ff[g], wb_dat_i, wb_sel_i);
        end else if (inc) begin
          cnt_ff[g] <= cnt_ff[g] + 1'b1;
        end
      end
    end
  endgenerate

  // ****************************************
  // overflow capture
  // ****************************************
  // lowest sampling counter wins when several overflow together
  // trade-off: a simultaneous overflow elsewhere loses its own sample
  always_comb begin
    fire = 1'b0;
    fire_code = '0;
    for (int i = NUM_CNT - 1; i >= 0; i--) begin
      if (ovf[i] && smp_en_ff[i]) begin
        fire = 1'b1;
        fire_code = evsel_ff[i][EV_W-1:0];
      end
    end
  end

  // address only for listed events, all-retired only when tagged
  always_comb begin
    qual = dla_is_qual(fire_code);
    st_meaning = dla_is_store(fire_code);
    if (fire_code == EV_ALL_RETIRED) begin
      qual = ret_tagged_i && (ret_is_load_i || ret_is_store_i);
      st_meaning = ret_tagged_i && ret_is_store_i;
    end
  end

  // load address or store destination; hit flag only for stores
  always_comb begin
    nxt_lin_addr = qual ? ret_lin_addr_i : 64'h0;
    nxt_store_stat = 64'h0;
    nxt_store_stat[STORE_HIT_BIT] = qual && st_meaning && ret_l1_hit_i;
  end

  // a record may only start while the writer is idle
  assign start = fire && !busy;

  // one record in flight; an overflow meanwhile is counted as dropped
  // limitation: the drop count wraps, so software should read it often
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drop_ff <= '0;
    end else if (fire && busy) begin
      drop_ff <= drop_ff + 1'b1;
    end
  end

  // records actually started, to match against what the buffer holds
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      smp_cnt_ff <= '0;
    end else if (start) begin
      smp_cnt_ff <= smp_cnt_ff + 1'b1;
    end
  end

  // record entries: next ip, address, status, zero, triggering ip
  dla_record_writer u_writer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(start),
    .next_ip_i(ret_next_ip_i),
    .lin_addr_i(nxt_lin_addr),
    .store_stat_i(nxt_store_stat),
    .evt_ip_i(ret_ip_i),
    .rec_ready_i(rec_ready_i),
    .busy_o(busy),
    .rec_valid_o(rec_valid_o),
    .rec_offset_o(rec_offset_o),
    .rec_data_o(rec_data_o),
    .rec_last_o(rec_last_o)
  );

  // ****************************************
  // off-core response filter
  // ****************************************
  // request, supplier, snoop fields packed from bit zero upward
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      filt_ff <= '0;
    end else if (wr_req && sel_flo) begin
      filt_ff[31:0] <= lanes(filt_ff[31:0], wb_dat_i, wb_sel_i);
    end else if (wr_req && sel_fhi && wb_sel_i[0]) begin
      filt_ff[FILT_W-1:32] <= wb_dat_i[FILT_W-33:0];
    end
  end

  // each request class is one-hot on oc_req_i, in filter bit order;
  // reserved request bits are masked so stray software ones do nothing
  // an all-zero snoop field means no snoop qualifier at all
  always_comb begin
    logic req_ok;
    logic supp_ok;
    logic snp_ok;
    logic [REQ_W-1:0] req_sel;
    logic [SUPP_W-1:0] supp_sel;
    logic [SNP_W-1:0] snp_sel;
    req_ok = 1'b0;
    supp_ok = 1'b0;
    snp_ok = 1'b0;
    req_sel = filt_ff[REQ_LSB +: REQ_W] & REQ_USED_MASK;
    supp_sel = filt_ff[SUPP_LSB +: SUPP_W];
    snp_sel = filt_ff[SNP_LSB +: SNP_W];
    req_ok = |(oc_req_i & req_sel);
    supp_ok = supp_sel[SUPP_ANY_BIT] || |(oc_supp_i & supp_sel);
    snp_ok = (snp_sel == '0) || |(oc_snoop_i & snp_sel);
    oc_match = oc_valid_i && req_ok && supp_ok && snp_ok;
  end

  // off-core event counter; software write wins over a match
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      oc_cnt_ff <= '0;
    end else if (wr_req && sel_occ) begin
      oc_cnt_ff <= lanes(oc_cnt_ff, wb_dat_i, wb_sel_i);
    end else if (oc_match) begin
      oc_cnt_ff <= oc_cnt_ff + 1'b1;
    end
  end
endmodule : dla_sampler

/* File: logic/dla_pkg.sv */
// constants, event codes and helpers shared by the sampling block
package dla_pkg;
  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam int WB_AW = 8;
  localparam logic [7:0] OFF_SAMPLE_EN = 8'h00;
  localparam logic [7:0] OFF_EVSEL0 = 8'h04;
  localparam logic [7:0] OFF_CNT0 = 8'h14;
  localparam logic [7:0] OFF_FILT_LO = 8'h24;
  localparam logic [7:0] OFF_FILT_HI = 8'h28;
  localparam logic [7:0] OFF_STATUS = 8'h2c;
  localparam logic [7:0] OFF_OC_CNT = 8'h30;
  localparam logic [7:0] OFF_STRIDE = 8'h04;
  // ****************************************
  // counters and event selectors
  // ****************************************
  localparam int NUM_CNT = 4;
  localparam int CNT_W = 32;
  localparam int EV_W = 5;
  localparam int NUM_EV = 20;
  localparam int EV_SPACE = 32;
  localparam int EVSEL_EN_BIT = 7;
  localparam logic [EV_W-1:0] EV_STLB_MISS_STORES = 5'h01;
  localparam logic [EV_W-1:0] EV_SPLIT_STORES = 5'h03;
  localparam logic [EV_W-1:0] EV_ALL_STORES = 5'h05;
  localparam logic [EV_W-1:0] EV_ALL_RETIRED = 5'h13;
  // ****************************************
  // sample record layout
  // ****************************************
  localparam int REC_ENTRIES = 5;
  localparam logic [7:0] REC_OFF_NEXT_IP = 8'h08;
  localparam logic [7:0] REC_OFF_LIN_ADDR = 8'h98;
  localparam logic [7:0] REC_OFF_STORE_STAT = 8'ha0;
  localparam logic [7:0] REC_OFF_RESERVED = 8'ha8;
  localparam logic [7:0] REC_OFF_EVT_IP = 8'hb0;
  localparam int STORE_HIT_BIT = 0;
  // ****************************************
  // off-core response filter fields
  // ****************************************
  localparam int FILT_W = 38;
  localparam int REQ_LSB = 0;
  localparam int REQ_W = 16;
  localparam int SUPP_LSB = 16;
  localparam int SUPP_W = 15;
  localparam int SNP_LSB = 31;
  localparam int SNP_W = 7;
  localparam logic [REQ_W-1:0] REQ_USED_MASK = 16'h8fff;
  localparam int SUPP_ANY_BIT = 0;
  // ****************************************
  // status register fields
  // ****************************************
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DROP_LSB = 8;
  localparam int STAT_SMP_LSB = 16;
  localparam int DROP_W = 8;
  localparam int SMP_W = 16;
  typedef enum logic [1:0] {
    DLA_WR_IDLE = 2'b00,
    DLA_WR_SEND = 2'b01
  } dla_wr_state_t;
  // events whose samples may carry a data address
  function automatic logic dla_is_qual(input logic [EV_W-1:0] code);
    return (code < EV_W'(NUM_EV));
  endfunction : dla_is_qual
  // events for which the store hit flag is meaningful
  function automatic logic dla_is_store(input logic [EV_W-1:0] code);
    return (code == EV_STLB_MISS_STORES) || (code == EV_SPLIT_STORES) ||
           (code == EV_ALL_STORES);
  endfunction : dla_is_store
endpackage : dla_pkg

/* File: logic/dla_record_writer.sv */
// serialiser that writes one latched sample record to the sample buffer
`timescale 1ns/10ps
module dla_record_writer
  import dla_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [63:0] next_ip_i,
  input wire logic [63:0] lin_addr_i,
  input wire logic [63:0] store_stat_i,
  input wire logic [63:0] evt_ip_i,
  input wire logic rec_ready_i,
  output logic busy_o,
  output logic rec_valid_o,
  output logic [7:0] rec_offset_o,
  output logic [63:0] rec_data_o,
  output logic rec_last_o
);
  dla_wr_state_t state_ff;
  logic [2:0] idx_ff;
  logic [63:0] nip_ff, la_ff, st_ff, eip_ff;

  // offset and contents of one record entry; the reserved slot is zero
  function automatic logic [71:0] entry(input logic [2:0] i, input logic [63:0] n,
      input logic [63:0] a, input logic [63:0] s, input logic [63:0] e);
    case (i)
      3'h0: return {REC_OFF_NEXT_IP, n};
      3'h1: return {REC_OFF_LIN_ADDR, a};
      3'h2: return {REC_OFF_STORE_STAT, s};
      3'h3: return {REC_OFF_RESERVED, 64'h0};
      default: return {REC_OFF_EVT_IP, e};
    endcase
  endfunction : entry

  assign busy_o = (state_ff != DLA_WR_IDLE);

  // fields are held here so the core may retire on while the record drains
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= DLA_WR_IDLE;
      idx_ff <= 3'h0;
      nip_ff <= 64'h0;
      la_ff <= 64'h0;
      st_ff <= 64'h0;
      eip_ff <= 64'h0;
      rec_valid_o <= 1'b0;
      rec_offset_o <= 8'h0;
      rec_data_o <= 64'h0;
      rec_last_o <= 1'b0;
    end else begin
      case (state_ff)
        DLA_WR_IDLE: begin
          if (start_i) begin
            nip_ff <= next_ip_i;
            la_ff <= lin_addr_i;
            st_ff <= store_stat_i;
            eip_ff <= evt_ip_i;
            idx_ff <= 3'h0;
            {rec_offset_o, rec_data_o} <= entry(3'h0, next_ip_i, lin_addr_i,
                store_stat_i, evt_ip_i);
            rec_valid_o <= 1'b1;
            rec_last_o <= 1'b0;
            state_ff <= DLA_WR_SEND;
          end
        end
        DLA_WR_SEND: begin
          if (rec_ready_i) begin
            if (rec_last_o) begin
              rec_valid_o <= 1'b0;
              rec_last_o <= 1'b0;
              state_ff <= DLA_WR_IDLE;
            end else begin
              idx_ff <= idx_ff + 3'h1;
              {rec_offset_o, rec_data_o} <= entry(idx_ff + 3'h1, nip_ff, la_ff,
                  st_ff, eip_ff);
              rec_last_o <= (idx_ff + 3'h1 == 3'(REC_ENTRIES - 1));
            end
          end
        end
        default: state_ff <= DLA_WR_IDLE;
      endcase
    end
  end
endmodule : dla_record_writer

/* File: testbench/dla_sampler_checker.sv */
// port checker for the data-address sampling block
`timescale 1ns/10ps
module dla_sampler_checker
  import dla_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic rec_ready_i,
  input wire logic rec_valid_o,
  input wire logic [7:0] rec_offset_o,
  input wire logic [63:0] rec_data_o,
  input wire logic rec_last_o
);
  // ****
  // record stream
  // ****
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // one entry handed to the buffer in this cycle
  sequence s_take(logic [7:0] o);
    rec_valid_o && rec_ready_i && rec_offset_o == o;
  endsequence
  // entries follow each other with no gap when the buffer keeps up
  property p_next(logic [7:0] a, logic [7:0] b);
    s_take(a) |=> rec_valid_o && rec_offset_o == b;
  endproperty
  chk_ip_then_addr: assert property (p_next(REC_OFF_NEXT_IP, REC_OFF_LIN_ADDR))
    else $error("address entry did not follow next ip entry");
  chk_addr_then_stat: assert property (p_next(REC_OFF_LIN_ADDR, REC_OFF_STORE_STAT))
    else $error("status entry did not follow address entry");
  chk_stat_then_resv: assert property (p_next(REC_OFF_STORE_STAT, REC_OFF_RESERVED))
    else $error("reserved entry did not follow status entry");
  chk_resv_then_trig: assert property (p_next(REC_OFF_RESERVED, REC_OFF_EVT_IP))
    else $error("trigger ip entry did not follow reserved entry");
  chk_entry_hold: assert property (rec_valid_o && !rec_ready_i |=>
    rec_valid_o && $stable(rec_offset_o) && $stable(rec_data_o))
    else $error("stalled entry changed");
  chk_reserved_zero: assert property (rec_valid_o && rec_offset_o == REC_OFF_RESERVED
    |-> rec_data_o == 64'h0)
    else $error("reserved entry not zero");
  chk_last_trigger: assert property (rec_valid_o && rec_last_o |->
    rec_offset_o == REC_OFF_EVT_IP)
    else $error("last flag on wrong entry");
  chk_record_gap: assert property (s_take(REC_OFF_EVT_IP) |=> !rec_valid_o)
    else $error("no idle cycle after record");
  // ****
  // register bus
  // ****
  chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("register access not answered in one cycle");
endmodule : dla_sampler_checker

bind dla_sampler dla_sampler_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .rec_ready_i(rec_ready_i),
  .rec_valid_o(rec_valid_o), .rec_offset_o(rec_offset_o), .rec_data_o(rec_data_o),
  .rec_last_o(rec_last_o));

/* File: testbench/dla_buffer_model.sv */
// sample buffer model that takes record entries with random stalls
`timescale 1ns/10ps
module dla_buffer_model (
  input wire logic clk_i,
  input wire logic rst_i,
  output logic rec_ready_o
);
  logic [15:0] lfsr_ff;
  // stalls about one cycle in four so that held entries get exercised
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lfsr_ff <= 16'hace1;
      rec_ready_o <= 1'b0;
    end else begin
      lfsr_ff <= {lfsr_ff[14:0], lfsr_ff[15] ^ lfsr_ff[13] ^ lfsr_ff[12] ^ lfsr_ff[10]};
      rec_ready_o <= lfsr_ff[1:0] != 2'b00;
    end
  end
endmodule : dla_buffer_model

/* File: testbench/dla_sampler_bench.sv */
// self-checking bench for the data-address sampling block
`timescale 1ns/10ps
module dla_sampler_bench;
  import dla_pkg::*;
  logic clk_i, rst_i, cyc, stb, we, ack, rv, ld, st, tg, hit, ocv, rdy, vld, last;
  logic [7:0] adr, off;
  logic [3:0] sel;
  logic [31:0] di, dout, ev, rng, v;
  logic [63:0] la, ip, nip, dat;
  logic [REQ_W-1:0] ocq;
  logic [SUPP_W-1:0] ocs;
  logic [SNP_W-1:0] ocn;
  int n_errors, checks_done, n;
  logic [72:0] rq[$], eq[$];
  logic [4:0] cd[7] = '{5'h05, 5'h01, 5'h00, 5'h03, 5'h13, 5'h13, 5'h13};
  logic stk[7] = '{1, 1, 0, 1, 0, 1, 1};
  logic tgk[7] = '{0, 0, 0, 0, 1, 0, 1};

  dla_sampler u_dla_sampler (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(di), .wb_dat_o(dout),
    .wb_ack_o(ack), .ret_valid_i(rv), .ret_event_i(ev), .ret_is_load_i(ld),
    .ret_is_store_i(st), .ret_tagged_i(tg), .ret_l1_hit_i(hit), .ret_lin_addr_i(la),
    .ret_ip_i(ip), .ret_next_ip_i(nip), .oc_valid_i(ocv), .oc_req_i(ocq), .oc_supp_i(ocs),
    .oc_snoop_i(ocn), .rec_ready_i(rdy), .rec_valid_o(vld), .rec_offset_o(off),
    .rec_data_o(dat), .rec_last_o(last));
  dla_buffer_model u_dla_buffer_model (.clk_i(clk_i), .rst_i(rst_i), .rec_ready_o(rdy));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : xs

  task automatic cmp(input logic [72:0] got, input logic [72:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic test_done();
    if (n_errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done

  // watchers pair each result with the oldest note; a stray result meets x
  always @(posedge clk_i) begin
    if (ack === 1'b1 && we === 1'b0) begin
      cmp({41'h0, dout}, rq.size() != 0 ? rq.pop_front() : 'x);
    end
    if (vld === 1'b1 && rdy === 1'b1) begin
      cmp({last, off, dat}, eq.size() != 0 ? eq.pop_front() : 'x);
    end
  end

  // classic single cycle; held until ack is seen at a rising edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    di <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back({41'h0, e});
    wb(1'b0, a, xs());
  endtask : rd

  task automatic retire(input logic [4:0] c, input logic s, input logic t, input logic h);
    @(posedge clk_i);
    rv <= 1'b1;
    ev <= (32'h1 << c) | (xs() & 32'hfff0_0000);
    ld <= !s;
    st <= s;
    tg <= t;
    hit <= h;
    la <= {xs(), xs()};
    ip <= {xs(), xs()};
    nip <= {xs(), xs()};
    @(posedge clk_i);
    rv <= 1'b0;
  endtask : retire

  task automatic oc(input logic [REQ_W-1:0] r, input logic [SUPP_W-1:0] s);
    @(posedge clk_i);
    ocv <= 1'b1;
    ocq <= r;
    ocs <= s;
    ocn <= SNP_W'(xs());
    @(posedge clk_i);
    ocv <= 1'b0;
  endtask : oc

  // ****
  // main sequence
  // ****
  initial begin
    {cyc, stb, we, rv, ld, st, tg, hit, ocv, adr, di, ev, la, ip, nip, ocq, ocs, ocn} = '0;
    sel = 4'hf;
    rng = 32'd86;
    n_errors = 0;
    checks_done = 0;
    n = 0;
    rst_i = 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(OFF_SAMPLE_EN, 32'h0);
    rd(OFF_FILT_LO, 32'h0);
    v = xs();
    wb(1'b1, OFF_FILT_LO, v);
    rd(OFF_FILT_LO, v);
    v = xs();
    wb(1'b1, OFF_FILT_HI, v);
    rd(OFF_FILT_HI, v & 32'h3f);
    wb(1'b1, 8'h3c, xs());
    rd(8'h3c, 32'h0);
    // software order: counter first, then selector, sample enable last
    for (int k = 0; k < 7; k++) begin
      logic [1:0] i;
      logic h, q, sm;
      i = 2'(k);
      h = 1'(xs());
      wb(1'b1, OFF_CNT0 + 8'(4 * i), 32'hffff_ffff);
      wb(1'b1, OFF_EVSEL0 + 8'(4 * i), 32'h80 | cd[k]);
      wb(1'b1, OFF_SAMPLE_EN, 32'h1 << i);
      retire(cd[k], stk[k], tgk[k], h);
      q = cd[k] != EV_ALL_RETIRED || tgk[k];
      // all-retired carries a hit flag only for a tagged store
      sm = (cd[k] == EV_ALL_RETIRED) ? stk[k] :
        (cd[k] inside {EV_STLB_MISS_STORES, EV_SPLIT_STORES, EV_ALL_STORES});
      eq.push_back({1'b0, REC_OFF_NEXT_IP, nip});
      eq.push_back({1'b0, REC_OFF_LIN_ADDR, q ? la : 64'h0});
      eq.push_back({1'b0, REC_OFF_STORE_STAT, 63'h0, h & q & sm});
      eq.push_back({1'b0, REC_OFF_RESERVED, 64'h0});
      eq.push_back({1'b1, REC_OFF_EVT_IP, ip});
      while (eq.size() != 0) @(posedge clk_i);
      rd(OFF_CNT0 + 8'(4 * i), 32'h0);
    end
    // overflow with sampling off must leave the buffer untouched
    wb(1'b1, OFF_CNT0, 32'hffff_ffff);
    wb(1'b1, OFF_EVSEL0, 32'h85);
    wb(1'b1, OFF_SAMPLE_EN, 32'h0);
    retire(5'h05, 1'b1, 1'b0, 1'b1);
    rd(OFF_CNT0, 32'h0);
    // a second overflow while the record drains is dropped, not queued
    wb(1'b1, OFF_CNT0, 32'hffff_ffff);
    wb(1'b1, OFF_SAMPLE_EN, 32'h1);
    retire(EV_ALL_STORES, 1'b1, 1'b0, 1'b1);
    eq.push_back({1'b0, REC_OFF_NEXT_IP, nip});
    eq.push_back({1'b0, REC_OFF_LIN_ADDR, la});
    eq.push_back({1'b0, REC_OFF_STORE_STAT, 64'h1});
    eq.push_back({1'b0, REC_OFF_RESERVED, 64'h0});
    eq.push_back({1'b1, REC_OFF_EVT_IP, ip});
    wb(1'b1, OFF_CNT0, 32'hffff_ffff);
    retire(EV_ALL_STORES, 1'b1, 1'b0, 1'b1);
    while (eq.size() != 0) @(posedge clk_i);
    // eight records started, one dropped, writer idle
    rd(OFF_STATUS, 32'h0008_0100);
    // walk every request bit with the any-supplier catch-all
    wb(1'b1, OFF_FILT_HI, 32'h0);
    for (int b = 0; b < 16; b++) begin
      wb(1'b1, OFF_FILT_LO, 32'h1_0000 | (32'h1 << b));
      oc(16'h1 << b, SUPP_W'(xs()));
      oc(16'h1 << ((b + 1) % 16), SUPP_W'(xs()));
      n += int'(REQ_USED_MASK[b]);
      rd(OFF_OC_CNT, n);
    end
    // supplier qualifier must also match
    wb(1'b1, OFF_FILT_LO, 32'h2_0001);
    oc(16'h1, 15'h2);
    oc(16'h1, 15'h4);
    rd(OFF_OC_CNT, n + 1);
    repeat (2) @(posedge clk_i);
    test_done();
  end

  // watchdog well beyond the expected run of a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    test_done();
  end
endmodule : dla_sampler_bench
